// >>> logic/hdmi_rx_event_status_latches.sv
// Sticky event status latches of a dual-port receiver, with clear and
// two mask sets, reached over AXI4-Lite; two level interrupt outputs.
// Assumes raw indications and bus inputs are synchronous to i_mclk.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps

module hdmi_rx_event_status_latches
  import irq_latch_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int PKT_W = 224
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Raw event indications
  input wire raw_levels_t i_levels,
  input wire logic i_first_recording_code_strobe,
  input wire logic [PKT_W-1:0] i_first_recording_code_body,
  input wire logic i_second_recording_code_strobe,
  input wire logic [PKT_W-1:0] i_second_recording_code_body,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Interrupt outputs
  output logic o_irq_output_one,
  output logic o_irq_output_two
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    raw_levels_t prev;               // Levels one clock ago
    logic primed;                    // Previous sample is valid
    logic [2:0][7:0] status;         // Sticky latches
    logic [2:0][7:0] mask_one;       // Enables for first output
    logic [2:0][7:0] mask_two;       // Enables for second output
    logic [PKT_W-1:0] first_body;    // Last first recording code
    logic [PKT_W-1:0] second_body;   // Last second recording code
    logic first_seen;                // A first code has arrived
    logic second_seen;               // A second code has arrived
    logic aw_held;                   // Write address captured
    logic w_held;                    // Write data captured
    logic [ADDR_W-1:0] awaddr;       // Captured write address
    logic [7:0] wbyte;               // Captured low data byte
    logic wlane;                     // Low byte lane strobe
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq_one;
    logic irq_two;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Combinational terms; all but evt and clr are also watched by the checks below
  raw_levels_t lvl_chg;              // Level change this cycle
  logic [2:0][7:0] evt;              // Set requests
  logic [2:0][7:0] clr;              // Clear requests
  logic [2:0][7:0] kept;             // Latches not being cleared
  logic [2:0][7:0] both;             // Set and clear together
  logic first_new;                   // First code with new content
  logic second_new;                  // Second code with new content

  // ****************************************************************
  // Address decoder, shared by the write and read paths
  // ****************************************************************
  function automatic reg_decode_t decode(input logic [ADDR_W-1:0] addr);
    reg_decode_t d;
    d.kind = KIND_NONE;
    d.bank = 2'h0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (addr[IDX_W+1:2] == STATUS_IDX[b]) begin
        d.kind = KIND_STATUS;
        d.bank = 2'(b);
      end else if (addr[IDX_W+1:2] == CLEAR_IDX[b]) begin
        d.kind = KIND_CLEAR;
        d.bank = 2'(b);
      end else if (addr[IDX_W+1:2] == MASK_ONE_IDX[b]) begin
        d.kind = KIND_MASK_ONE;
        d.bank = 2'(b);
      end else if (addr[IDX_W+1:2] == MASK_TWO_IDX[b]) begin
        d.kind = KIND_MASK_TWO;
        d.bank = 2'(b);
      end
    end
    return d;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Event detection, bus slave and latch update in one pass
  always_comb begin
    reg_decode_t wdec;
    reg_decode_t rdec;
    wdec = decode(state_reg.awaddr);
    rdec = decode(i_araddr);
    state_next = state_reg;
    evt = '0;
    clr = '0;

    // Any edge of a level counts, so compare with last sample
    lvl_chg = i_levels ^ state_reg.prev;
    state_next.prev = i_levels;
    state_next.primed = 1'b1;
    // First cycle after reset has no valid history, so no level events
    if (state_reg.primed) begin
      evt[BANK_L3] = lvl_chg[10:3];
      evt[BANK_L4] = {5'h00, lvl_chg[2:0]};
    end

    // Packet latches fire only on content that differs
    first_new = i_first_recording_code_strobe &&
                (!state_reg.first_seen || i_first_recording_code_body != state_reg.first_body);
    second_new = i_second_recording_code_strobe &&
                 (!state_reg.second_seen || i_second_recording_code_body != state_reg.second_body);
    if (i_first_recording_code_strobe) begin
      state_next.first_body = i_first_recording_code_body;
      state_next.first_seen = 1'b1;
    end
    if (i_second_recording_code_strobe) begin
      state_next.second_body = i_second_recording_code_body;
      state_next.second_seen = 1'b1;
    end
    evt[BANK_E1][BIT_FIRST_CODE] = first_new;
    evt[BANK_E1][BIT_SECOND_CODE] = second_new;

    // Address and data are taken independently, in either order
    if (i_awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr = i_awaddr;
    end
    if (i_wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.wbyte = i_wdata[7:0];
      state_next.wlane = i_wstrb[0];
    end

    // Both halves present: perform the write and answer
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      state_next.bresp = RESP_OKAY;
      unique case (wdec.kind)
        KIND_CLEAR: begin
          // Write one to clear; only the low lane carries latch bits
          if (state_reg.wlane) begin
            clr[wdec.bank] = state_reg.wbyte;
          end
        end
        KIND_MASK_ONE: begin
          if (state_reg.wlane) begin
            state_next.mask_one[wdec.bank] = state_reg.wbyte & IMPL_MASK[wdec.bank];
          end
        end
        KIND_MASK_TWO: begin
          if (state_reg.wlane) begin
            state_next.mask_two[wdec.bank] = state_reg.wbyte & IMPL_MASK[wdec.bank];
          end
        end
        KIND_STATUS: begin
          // Status is read only; the write is accepted and ignored
        end
        default: begin
          state_next.bresp = RESP_SLVERR;
        end
      endcase
      state_next.bvalid = 1'b1;
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
    end else if (state_reg.bvalid && i_bready) begin
      state_next.bvalid = 1'b0;
    end
    // No new write is taken until the response has gone
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready = !state_next.w_held && !state_next.bvalid;

    // Read path: one outstanding read, answered the cycle after taking
    if (i_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      unique case (rdec.kind)
        KIND_STATUS: begin
          state_next.rdata = {24'h000000, state_reg.status[rdec.bank]};
        end
        KIND_MASK_ONE: begin
          state_next.rdata = {24'h000000, state_reg.mask_one[rdec.bank]};
        end
        KIND_MASK_TWO: begin
          state_next.rdata = {24'h000000, state_reg.mask_two[rdec.bank]};
        end
        KIND_CLEAR: begin
          // Clear registers are write only and read as zero
          state_next.rdata = 32'h00000000;
        end
        default: begin
          state_next.rdata = 32'h00000000;
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rvalid && i_rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.arready = !state_next.rvalid;

    // Latch update: the set term is or-ed last, so it wins
    for (int b = 0; b < NUM_BANKS; b++) begin
      kept[b] = state_reg.status[b] & ~clr[b];
      both[b] = evt[b] & clr[b];
      state_next.status[b] = (kept[b] | evt[b]) & IMPL_MASK[b];
    end

    // Outputs follow the enabled latches from the same edge
    state_next.irq_one = |(state_next.status & state_next.mask_one);
    state_next.irq_two = |(state_next.status & state_next.mask_two);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Synchronous reset clears all latches, masks and bus state
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign o_awready = state_reg.awready;
  assign o_wready = state_reg.wready;
  assign o_bvalid = state_reg.bvalid;
  assign o_bresp = state_reg.bresp;
  assign o_arready = state_reg.arready;
  assign o_rvalid = state_reg.rvalid;
  assign o_rdata = state_reg.rdata;
  assign o_rresp = state_reg.rresp;
  assign o_irq_output_one = state_reg.irq_one;
  assign o_irq_output_two = state_reg.irq_two;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  // Arrival of a differing first recording code
  sequence first_code_arrives;
    first_new;
  endsequence

  // Arrival of a differing second recording code
  sequence second_code_arrives;
    second_new;
  endsequence

  AST_PORT_B_SUPPLY: assert property (state_reg.primed && lvl_chg.port_b_supply_seen_level |=>
      state_reg.status[BANK_L3][BIT_PORT_B_SUPPLY])
    else $error("port B supply change not latched");
  AST_STICKY: assert property (1'b1 |=> ((state_reg.status & $past(kept)) == $past(kept)))
    else $error("latch dropped without a clear");
  AST_IRQ_ONE: assert property (o_irq_output_one == |(state_reg.status & state_reg.mask_one))
    else $error("first interrupt output does not match enabled latches");
  AST_IRQ_TWO: assert property (o_irq_output_two == |(state_reg.status & state_reg.mask_two))
    else $error("second interrupt output does not match enabled latches");
  AST_PORT_A_PLL: assert property (state_reg.primed && lvl_chg.port_a_pll_lock_level |=>
      state_reg.status[BANK_L3][BIT_PORT_A_PLL])
    else $error("port A PLL lock change not latched");
  AST_PORT_B_PLL: assert property (state_reg.primed && lvl_chg.port_b_pll_lock_level |=>
      state_reg.status[BANK_L3][BIT_PORT_B_PLL])
    else $error("port B PLL lock change not latched");
  AST_PORT_A_CLOCK: assert property (state_reg.primed && lvl_chg.port_a_clock_seen_level |=>
      state_reg.status[BANK_L3][BIT_PORT_A_CLOCK])
    else $error("port A clock detect change not latched");
  AST_PORT_B_CLOCK: assert property (state_reg.primed && lvl_chg.port_b_clock_seen_level |=>
      state_reg.status[BANK_L3][BIT_PORT_B_CLOCK])
    else $error("port B clock detect change not latched");
  AST_STEREO: assert property (state_reg.primed && lvl_chg.stereo_video_level |=>
      state_reg.status[BANK_L3][BIT_STEREO])
    else $error("stereo video change not latched");
  AST_VSYNC_LOCK: assert property (state_reg.primed && lvl_chg.vsync_filter_lock_level |=>
      state_reg.status[BANK_L3][BIT_VSYNC_LOCK])
    else $error("vsync filter lock change not latched");
  AST_REGEN_LOCK: assert property (state_reg.primed && lvl_chg.enable_regen_lock_level |=>
      state_reg.status[BANK_L3][BIT_REGEN_LOCK])
    else $error("regeneration lock change not latched");
  AST_PORT_A_CIPHER: assert property (state_reg.primed && lvl_chg.port_a_cipher_seen_level |=>
      state_reg.status[BANK_L4][BIT_PORT_A_CIPHER])
    else $error("port A cipher change not latched");
  AST_PORT_B_CIPHER: assert property (state_reg.primed && lvl_chg.port_b_cipher_seen_level |=>
      state_reg.status[BANK_L4][BIT_PORT_B_CIPHER])
    else $error("port B cipher change not latched");
  AST_PORT_A_SUPPLY: assert property (state_reg.primed && lvl_chg.port_a_supply_seen_level |=>
      state_reg.status[BANK_L4][BIT_PORT_A_SUPPLY])
    else $error("port A supply change not latched");
  AST_SECOND_CODE: assert property (second_code_arrives |=> state_reg.status[BANK_E1][BIT_SECOND_CODE])
    else $error("new second recording code not latched");
  AST_FIRST_CODE: assert property (first_code_arrives |=> state_reg.status[BANK_E1][BIT_FIRST_CODE])
    else $error("new first recording code not latched");
  AST_FIRST_REPEAT: assert property (!state_reg.status[BANK_E1][BIT_FIRST_CODE] && !first_new |=>
      !state_reg.status[BANK_E1][BIT_FIRST_CODE])
    else $error("first recording code latch set without new content");
  AST_FALLING_EDGE: assert property (state_reg.primed && state_reg.prev.stereo_video_level &&
      !i_levels.stereo_video_level |=> state_reg.status[BANK_L3][BIT_STEREO])
    else $error("falling edge of stereo video not latched");
  AST_SET_WINS: assert property (both != '0 |=> ((state_reg.status & $past(both)) == $past(both)))
    else $error("event lost to a simultaneous clear");

endmodule

// >>> logic/irq_latch_pkg.sv
// Constants and carrier types for the receiver event status latch bank.
// Assumes a single 40 MHz control clock and AXI4-Lite register access.
package irq_latch_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam int IDX_W = 10;
  localparam int NUM_BANKS = 3;
  // Bank order: level status three, level status four, edge status one
  localparam int BANK_L3 = 0;
  localparam int BANK_L4 = 1;
  localparam int BANK_E1 = 2;
  localparam logic [2:0][IDX_W-1:0] STATUS_IDX = {10'h07A, 10'h070, 10'h06B};
  localparam logic [2:0][IDX_W-1:0] CLEAR_IDX = {10'h07B, 10'h071, 10'h06C};
  localparam logic [2:0][IDX_W-1:0] MASK_ONE_IDX = {10'h07C, 10'h072, 10'h06D};
  localparam logic [2:0][IDX_W-1:0] MASK_TWO_IDX = {10'h07D, 10'h073, 10'h06E};
  // Bits that really exist in each bank; the rest read as zero
  localparam logic [2:0][7:0] IMPL_MASK = {8'hC0, 8'h07, 8'hFF};
  localparam logic [2:0][7:0] LATCH_RESET = {8'h00, 8'h00, 8'h00};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_PORT_B_SUPPLY = 7;
  localparam int BIT_PORT_A_PLL = 6;
  localparam int BIT_PORT_B_PLL = 5;
  localparam int BIT_PORT_A_CLOCK = 4;
  localparam int BIT_PORT_B_CLOCK = 3;
  localparam int BIT_STEREO = 2;
  localparam int BIT_VSYNC_LOCK = 1;
  localparam int BIT_REGEN_LOCK = 0;
  localparam int BIT_PORT_A_CIPHER = 2;
  localparam int BIT_PORT_B_CIPHER = 1;
  localparam int BIT_PORT_A_SUPPLY = 0;
  localparam int BIT_SECOND_CODE = 7;
  localparam int BIT_FIRST_CODE = 6;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Raw level indications; bits [10:3] map onto level status three,
  // bits [2:0] onto level status four
  typedef struct packed {
    logic port_b_supply_seen_level;
    logic port_a_pll_lock_level;
    logic port_b_pll_lock_level;
    logic port_a_clock_seen_level;
    logic port_b_clock_seen_level;
    logic stereo_video_level;
    logic vsync_filter_lock_level;
    logic enable_regen_lock_level;
    logic port_a_cipher_seen_level;
    logic port_b_cipher_seen_level;
    logic port_a_supply_seen_level;
  } raw_levels_t;

  // Register kinds seen by the address decoder
  typedef enum logic [2:0] {KIND_NONE, KIND_STATUS, KIND_CLEAR, KIND_MASK_ONE, KIND_MASK_TWO} reg_kind_t;

  typedef struct packed {
    reg_kind_t kind;
    logic [1:0] bank;
  } reg_decode_t;

endpackage

// >>> tb/hdmi_rx_event_status_latches_tb.sv
// Self-checking bench for the receiver event status latch bank.
// Assumes the design package is compiled first; the bench is the only bus master.
`timescale 1ns/1ps
`define CHK(a,b) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module hdmi_rx_event_status_latches_tb;
  import irq_latch_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int PKT_W = 224;
  localparam int LIMIT = 20000; // Whole run needs well under a thousand cycles
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  raw_levels_t i_levels = '0;
  logic i_first_recording_code_strobe = 1'b0;
  logic [PKT_W-1:0] i_first_recording_code_body = '0;
  logic i_second_recording_code_strobe = 1'b0;
  logic [PKT_W-1:0] i_second_recording_code_body = '0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [11:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0] i_wdata = '0;
  logic [3:0] i_wstrb = '0;
  logic [3:0] strb = 4'hF; // Lanes offered by the next write; low lane off means no effect
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq_output_one, o_irq_output_two;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  int n_errors = 0; // Mismatches seen
  int n_compared = 0; // Comparisons made
  int cyc = 0; // Cycle count for the hang guard

  hdmi_rx_event_status_latches #(.ADDR_W(12), .PKT_W(PKT_W)) uut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_levels(i_levels),
    .i_first_recording_code_strobe(i_first_recording_code_strobe),
    .i_first_recording_code_body(i_first_recording_code_body),
    .i_second_recording_code_strobe(i_second_recording_code_strobe),
    .i_second_recording_code_body(i_second_recording_code_body),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_irq_output_one(o_irq_output_one), .o_irq_output_two(o_irq_output_two));

  // ****************************************************************
  // Clock, hang guard and closing report
  // ****************************************************************
  always #12.5 i_mclk = ~i_mclk;

  // Counting a hang as a mismatch keeps the verdict in one place
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  function automatic logic [11:0] ad(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  // Offers address and data together; each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    // Valid goes up without waiting for ready and stands until taken
    @(posedge i_mclk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= strb;
    i_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_mclk);
      if (i_awvalid && o_awready) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_mclk); while (!o_bvalid);
    i_bready <= 1'b0;
    `CHK(o_bresp, er)
  endtask

  // Reads one word and compares data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_mclk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do @(posedge i_mclk); while (!(i_arvalid && o_arready));
    i_arvalid <= 1'b0;
    do @(posedge i_mclk); while (!o_rvalid);
    i_rready <= 1'b0;
    `CHK(o_rdata, e)
    `CHK(o_rresp, er)
  endtask

  // One packet strobe with its body
  task automatic pkt(input int s, input logic [PKT_W-1:0] v);
    @(posedge i_mclk);
    i_first_recording_code_strobe <= (s == 0);
    i_first_recording_code_body <= v;
    i_second_recording_code_strobe <= (s == 1);
    i_second_recording_code_body <= v;
    @(posedge i_mclk);
    i_first_recording_code_strobe <= 1'b0;
    i_second_recording_code_strobe <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_and_map();
    for (int b = 0; b < NUM_BANKS; b++) begin
      rd(ad(STATUS_IDX[b]), 32'h0, RESP_OKAY);
      wr(ad(MASK_ONE_IDX[b]), 32'hFF, RESP_OKAY);
      rd(ad(MASK_ONE_IDX[b]), {24'h0, IMPL_MASK[b]}, RESP_OKAY);
      wr(ad(MASK_ONE_IDX[b]), 32'h0, RESP_OKAY);
      wr(ad(MASK_TWO_IDX[b]), 32'hFF, RESP_OKAY);
      rd(ad(MASK_TWO_IDX[b]), {24'h0, IMPL_MASK[b]}, RESP_OKAY);
      wr(ad(MASK_TWO_IDX[b]), 32'h0, RESP_OKAY);
    end
    // A write without the low byte lane must leave the mask alone
    strb = 4'hE;
    wr(ad(MASK_ONE_IDX[BANK_L3]), 32'hFF, RESP_OKAY);
    strb = 4'hF;
    rd(ad(MASK_ONE_IDX[BANK_L3]), 32'h0, RESP_OKAY);
    `CHK(o_irq_output_one, 1'b0)
    rd(12'hFFC, 32'h0, RESP_SLVERR);
    wr(12'hFFC, 32'hFF, RESP_SLVERR);
    wr(ad(STATUS_IDX[BANK_L3]), 32'hFF, RESP_OKAY);
    rd(ad(STATUS_IDX[BANK_L3]), 32'h0, RESP_OKAY);
    rd(ad(CLEAR_IDX[BANK_L3]), 32'h0, RESP_OKAY);
    $display("test reset_and_map done");
  endtask

  task automatic t_levels();
    int b;
    logic [31:0] m;
    for (int k = 0; k < 11; k++) begin
      b = (k >= 3) ? BANK_L3 : BANK_L4;
      m = 32'h1 << ((k >= 3) ? k - 3 : k);
      i_levels <= i_levels ^ (11'h001 << k);
      rd(ad(STATUS_IDX[b]), m, RESP_OKAY);
      wr(ad(CLEAR_IDX[b]), ~m, RESP_OKAY);
      rd(ad(STATUS_IDX[b]), m, RESP_OKAY);
      wr(ad(CLEAR_IDX[b]), m, RESP_OKAY);
      rd(ad(STATUS_IDX[b]), 32'h0, RESP_OKAY);
      i_levels <= i_levels ^ (11'h001 << k);
      rd(ad(STATUS_IDX[b]), m, RESP_OKAY);
      wr(ad(CLEAR_IDX[b]), m, RESP_OKAY);
    end
    $display("test levels done");
  endtask

  task automatic t_packets();
    logic [31:0] m;
    for (int s = 0; s < 2; s++) begin
      m = (s == 0) ? 32'h40 : 32'h80;
      pkt(s, {7{32'hA5A5_0F0F}});
      rd(ad(STATUS_IDX[BANK_E1]), m, RESP_OKAY);
      wr(ad(CLEAR_IDX[BANK_E1]), m, RESP_OKAY);
      pkt(s, {7{32'hA5A5_0F0F}});
      rd(ad(STATUS_IDX[BANK_E1]), 32'h0, RESP_OKAY);
      pkt(s, {7{32'hA5A5_0F0E}});
      rd(ad(STATUS_IDX[BANK_E1]), m, RESP_OKAY);
      wr(ad(CLEAR_IDX[BANK_E1]), m, RESP_OKAY);
    end
    $display("test packets done");
  endtask

  task automatic t_irq();
    wr(ad(MASK_ONE_IDX[BANK_L3]), 32'h01, RESP_OKAY);
    i_levels <= i_levels ^ 11'h008;
    rd(ad(STATUS_IDX[BANK_L3]), 32'h01, RESP_OKAY);
    `CHK({o_irq_output_one, o_irq_output_two}, 2'b10)
    wr(ad(MASK_TWO_IDX[BANK_L3]), 32'h01, RESP_OKAY);
    `CHK({o_irq_output_one, o_irq_output_two}, 2'b11)
    wr(ad(MASK_ONE_IDX[BANK_L3]), 32'h00, RESP_OKAY);
    `CHK({o_irq_output_one, o_irq_output_two}, 2'b01)
    wr(ad(CLEAR_IDX[BANK_L3]), 32'h01, RESP_OKAY);
    `CHK({o_irq_output_one, o_irq_output_two}, 2'b00)
    wr(ad(MASK_TWO_IDX[BANK_L3]), 32'h00, RESP_OKAY);
    $display("test irq done");
  endtask

  // Clear landing on the same edge as a fresh change must not lose it
  task automatic t_race();
    i_levels <= i_levels ^ 11'h010;
    rd(ad(STATUS_IDX[BANK_L3]), 32'h02, RESP_OKAY);
    fork
      wr(ad(CLEAR_IDX[BANK_L3]), 32'h02, RESP_OKAY);
      begin
        do @(posedge i_mclk); while (!(i_awvalid && o_awready));
        i_levels <= i_levels ^ 11'h010;
      end
    join
    rd(ad(STATUS_IDX[BANK_L3]), 32'h02, RESP_OKAY);
    wr(ad(CLEAR_IDX[BANK_L3]), 32'h02, RESP_OKAY);
    rd(ad(STATUS_IDX[BANK_L3]), 32'h00, RESP_OKAY);
    $display("test race done");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_mclk);
    t_reset_and_map();
    t_levels();
    t_packets();
    t_irq();
    t_race();
    results();
  end
endmodule
